// ### hdl/m2m_dma_ptr_cfg.svh
// Register offsets, field positions and reset values of the DMA pointer block
`ifndef M2M_DMA_PTR_CFG_SVH
`define M2M_DMA_PTR_CFG_SVH
`define OFS_CONTROL       8'h00
`define OFS_STATUS        8'h04
`define OFS_BYTE_COUNT0   8'h10
`define OFS_BYTE_COUNT1   8'h14
`define OFS_SRC_BASE0     8'h18
`define OFS_SRC_BASE1     8'h1C
`define OFS_CUR_SRC0      8'h24
`define OFS_CUR_SRC1      8'h28
`define OFS_DST_BASE0     8'h2C
`define OFS_DST_BASE1     8'h30
`define OFS_CUR_DST0      8'h34
`define OFS_CUR_DST1      8'h3C
`define CTL_ENABLE_BIT    0
`define CTL_START_BIT     1
`define CTL_WIDTH_LSB     2
`define WIDTH_BYTE        2'h0
`define WIDTH_HALF        2'h1
`define RST_WORD          32'h0000_0000
`define RST_COUNT         16'h0000
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// ### hdl/m2m_dma_ptr_pkg.sv
// Types shared by the DMA pointer block and its users
package m2m_dma_ptr_pkg;
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STALL,
    ST_MOVE
  } ptr_state_type;
endpackage : m2m_dma_ptr_pkg

// ### hdl/m2m_dma_address_pointers.sv
// Address pointers of a two-descriptor memory-to-memory DMA channel
// What this block does and what software must do
// (R1) A byte count write to a descriptor not in flight copies its source base into its current source pointer and marks it active.
// (R2) The same byte count write copies the destination base into the current destination pointer.
// (R3) At the end of a buffer the post-incremented source address stays in its current source pointer.
// (R4) At the end of a buffer the post-incremented destination address stays in its current destination pointer.
// (R5) Software sets a non-zero destination base before it enables or starts the channel.
// (R6) Writes to the idle descriptor during a transfer leave the running transfer untouched.
// (R7) For a peripheral destination software loads the peripheral's base address.
// (R8) Software aligns peripheral base addresses to the peripheral width.
// (R9) The current source pointers answer at offsets 0x24 and 0x28.
// (R10) The destination bases answer at 0x2C and 0x30, read-write, reset zero.
// (R11) The current destination pointers answer at 0x34 and 0x3C.
// (R12) A current source pointer reads the live source address, read-only, reset zero.
// (R13) A current destination pointer reads the live destination address, reset zero.
// (R14) Writing the 16-bit byte count of a descriptor that is not in flight arms it for the buffer switch.
// (R15) A trigger with a zero active byte count moves nothing and leaves the channel stalled.
// (R16) Each completed beat advances both current pointers by the bytes moved.
`timescale 1ns/1ps
`include "m2m_dma_ptr_cfg.svh"
`default_nettype none
module m2m_dma_address_pointers (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // Register bus
  input  wire m2m_dma_ptr_pkg::axil_req_type axi_req,
  output      m2m_dma_ptr_pkg::axil_rsp_type axi_rsp,
  // Transfer engine
  input  wire logic                        hw_trigger,
  input  wire logic                        beat_done,
  output      logic                        beat_req,
  output      logic [31:0]                 beat_src_addr,
  output      logic [31:0]                 beat_dst_addr,
  output      logic [2:0]                  beat_bytes,
  output      logic                        active_buf,
  output      logic                        stalled,
  output      logic                        buffer_done
);
  import m2m_dma_ptr_pkg::*;

  ptr_state_type state_reg;
  ptr_state_type state_next;
  logic [7:0]    awaddr_reg, wr_addr, rd_addr;
  logic [31:0]   wdata_reg, rdata_reg, rd_mux;
  logic [3:0]    wstrb_reg;
  logic [1:0]    bresp_reg, rresp_reg, periph_width_reg;
  logic [31:0]   src_base_addr [2];
  logic [31:0]   dst_base_addr [2];
  logic [31:0]   current_src_ptr [2];
  logic [31:0]   current_dst_ptr [2];
  logic [15:0]   bytes_remaining [2];
  // One bit per descriptor
  logic [1:0]    buf_active_reg, bc_wr, moving, beat_hit, finish;
  // Bus channel state
  logic          aw_have_reg, w_have_reg, bvalid_reg, rvalid_reg;
  logic          wr_fire, wr_hit, ar_fire, rd_hit, ctl_wr;
  // Sequencer state
  logic          enable_reg, enable_now, start_pulse, trigger;
  logic          act_idx_reg, act_idx_next, pick_idx, other_ready;
  logic          last_beat, done_reg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] mask;
    mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~mask) | (val & mask);
  endfunction : merge

  // Bus handshakes; a held address or data word blocks the next until the response
  assign wr_addr     = {awaddr_reg[7:2], 2'h0};
  assign wr_fire     = aw_have_reg && w_have_reg && !bvalid_reg;
  assign ar_fire     = axi_req.arvalid && !rvalid_reg;
  assign rd_addr     = {axi_req.araddr[7:2], 2'h0};
  assign ctl_wr      = wr_fire && wr_addr == `OFS_CONTROL;
  assign start_pulse = ctl_wr && wstrb_reg[0] && wdata_reg[`CTL_START_BIT];
  // Enable and start in one write must launch at once
  assign enable_now  = ctl_wr && wstrb_reg[0] ? wdata_reg[`CTL_ENABLE_BIT] : enable_reg;
  function automatic logic is_mapped(input logic [7:0] a);
    return a == `OFS_CONTROL || a == `OFS_STATUS || a == `OFS_BYTE_COUNT0 ||
           a == `OFS_BYTE_COUNT1 || a == `OFS_SRC_BASE0 || a == `OFS_SRC_BASE1 ||
           a == `OFS_CUR_SRC0 || a == `OFS_CUR_SRC1 || a == `OFS_DST_BASE0 ||
           a == `OFS_DST_BASE1 || a == `OFS_CUR_DST0 || a == `OFS_CUR_DST1;
  endfunction : is_mapped
  assign wr_hit = is_mapped(wr_addr);
  assign rd_hit = is_mapped(rd_addr);

  // Current pointers read straight from the live registers
  assign rd_mux =
    rd_addr == `OFS_CONTROL     ? {28'h0, periph_width_reg, 1'b0, enable_reg} :
    rd_addr == `OFS_STATUS      ? {26'h0, stalled, beat_req, act_idx_reg, 1'b0, buf_active_reg} :
    rd_addr == `OFS_BYTE_COUNT0 ? {16'h0, bytes_remaining[0]} :
    rd_addr == `OFS_BYTE_COUNT1 ? {16'h0, bytes_remaining[1]} :
    rd_addr == `OFS_SRC_BASE0   ? src_base_addr[0] :
    rd_addr == `OFS_SRC_BASE1   ? src_base_addr[1] :
    rd_addr == `OFS_CUR_SRC0    ? current_src_ptr[0] : // R9 R12
    rd_addr == `OFS_CUR_SRC1    ? current_src_ptr[1] : // R9 R12
    rd_addr == `OFS_DST_BASE0   ? dst_base_addr[0] : // R10
    rd_addr == `OFS_DST_BASE1   ? dst_base_addr[1] : // R10
    rd_addr == `OFS_CUR_DST0    ? current_dst_ptr[0] : // R11 R13
    rd_addr == `OFS_CUR_DST1    ? current_dst_ptr[1] : 32'h0; // R11 R13

  assign axi_rsp.awready = !aw_have_reg;
  assign axi_rsp.wready  = !w_have_reg;
  assign axi_rsp.bvalid  = bvalid_reg;
  assign axi_rsp.bresp   = bresp_reg;
  assign axi_rsp.arready = !rvalid_reg;
  assign axi_rsp.rvalid  = rvalid_reg;
  assign axi_rsp.rdata   = rdata_reg;
  assign axi_rsp.rresp   = rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
    end else if (axi_req.awvalid && !aw_have_reg) begin
      aw_have_reg <= 1'b1;
      awaddr_reg  <= axi_req.awaddr;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg <= 1'b0;
      wdata_reg  <= `RST_WORD;
      wstrb_reg  <= 4'h0;
    end else if (axi_req.wvalid && !w_have_reg) begin
      w_have_reg <= 1'b1;
      wdata_reg  <= axi_req.wdata;
      wstrb_reg  <= axi_req.wstrb;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (axi_req.bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= `RST_WORD;
      rresp_reg  <= `RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (axi_req.rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg       <= 1'b0;
      periph_width_reg <= `WIDTH_BYTE;
    end else if (ctl_wr && wstrb_reg[0]) begin
      enable_reg       <= wdata_reg[`CTL_ENABLE_BIT];
      periph_width_reg <= wdata_reg[`CTL_WIDTH_LSB +: 2];
    end
  end

  // Beat size from peripheral width; the spare code also means word
  assign beat_bytes = periph_width_reg == `WIDTH_BYTE ? 3'h1 :
                      periph_width_reg == `WIDTH_HALF ? 3'h2 : 3'h4;
  assign last_beat  = bytes_remaining[act_idx_reg] <= {13'h0, beat_bytes};

  // Per descriptor: base registers, count and the two current pointers
  for (genvar i = 0; i < 2; i++) begin : g_desc
    localparam logic [7:0] OFS_BC = i ? `OFS_BYTE_COUNT1 : `OFS_BYTE_COUNT0;
    localparam logic [7:0] OFS_SB = i ? `OFS_SRC_BASE1 : `OFS_SRC_BASE0;
    localparam logic [7:0] OFS_DB = i ? `OFS_DST_BASE1 : `OFS_DST_BASE0;
    localparam logic [7:0] OFS_CD = i ? `OFS_CUR_DST1 : `OFS_CUR_DST0;
    // A descriptor in flight ignores its own reload so the beat stream stays coherent
    assign moving[i]   = state_reg == ST_MOVE && act_idx_reg == 1'(i); // R6
    assign bc_wr[i]    = wr_fire && wr_addr == OFS_BC && !moving[i]; // R14
    assign beat_hit[i] = moving[i] && beat_done;
    assign finish[i]   = beat_hit[i] && last_beat;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        src_base_addr[i] <= `RST_WORD;
        dst_base_addr[i] <= `RST_WORD;
      end else begin
        if (wr_fire && wr_addr == OFS_SB) begin
          src_base_addr[i] <= merge(src_base_addr[i], wdata_reg, wstrb_reg);
        end
        if (wr_fire && wr_addr == OFS_DB) begin
          dst_base_addr[i] <= merge(dst_base_addr[i], wdata_reg, wstrb_reg); // R10
        end
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        current_src_ptr[i] <= `RST_WORD;
        current_dst_ptr[i] <= `RST_WORD;
        bytes_remaining[i] <= `RST_COUNT;
      end else if (bc_wr[i]) begin
        current_src_ptr[i] <= src_base_addr[i]; // R1
        current_dst_ptr[i] <= dst_base_addr[i]; // R2
        bytes_remaining[i] <= {wstrb_reg[1] ? wdata_reg[15:8] : bytes_remaining[i][15:8],
                               wstrb_reg[0] ? wdata_reg[7:0] : bytes_remaining[i][7:0]}; // R14
      end else if (beat_hit[i]) begin
        // Pointers left after the final beat mark where the buffer ended
        current_src_ptr[i] <= current_src_ptr[i] + {29'h0, beat_bytes}; // R3 R16
        current_dst_ptr[i] <= current_dst_ptr[i] + {29'h0, beat_bytes}; // R4 R16
        bytes_remaining[i] <= last_beat ? 16'h0000 :
                              bytes_remaining[i] - {13'h0, beat_bytes};
      end else if (wr_fire && wr_addr == OFS_CD && !moving[i]) begin
        current_dst_ptr[i] <= merge(current_dst_ptr[i], wdata_reg, wstrb_reg); // R13
      end
    end

    // Arming wins over the end of the buffer in the same cycle; a descriptor in flight ignores its own reload
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        buf_active_reg[i] <= 1'b0;
      end else if (bc_wr[i]) begin
        buf_active_reg[i] <= 1'b1; // R1
      end else if (finish[i]) begin
        buf_active_reg[i] <= 1'b0;
      end
    end
  end

  // Sequencer: which descriptor runs and when the channel stalls
  assign trigger     = enable_now && (start_pulse || hw_trigger);
  assign pick_idx    = buf_active_reg[act_idx_reg] ? act_idx_reg : !act_idx_reg;
  assign other_ready = buf_active_reg[!act_idx_reg] && bytes_remaining[!act_idx_reg] != 16'h0;

  always_comb begin
    state_next   = state_reg;
    act_idx_next = act_idx_reg;
    case (state_reg)
      ST_IDLE: begin
        if (trigger) begin
          act_idx_next = pick_idx;
          if (buf_active_reg[pick_idx] && bytes_remaining[pick_idx] != 16'h0) begin
            state_next = ST_MOVE;
          end else begin
            state_next = ST_STALL; // R15
          end
        end
      end
      ST_STALL: begin
        if (!enable_reg) begin
          state_next = ST_IDLE;
        end
      end
      ST_MOVE: begin
        if (!enable_reg) begin
          state_next = ST_IDLE;
        end else if (finish[act_idx_reg]) begin
          if (other_ready) begin
            act_idx_next = !act_idx_reg; // R14
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= ST_IDLE;
      act_idx_reg <= 1'b0;
      done_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      act_idx_reg <= act_idx_next;
      done_reg    <= |finish;
    end
  end

  assign beat_req      = state_reg == ST_MOVE;
  assign beat_src_addr = current_src_ptr[act_idx_reg];
  assign beat_dst_addr = current_dst_ptr[act_idx_reg];
  assign active_buf    = act_idx_reg;
  assign stalled       = state_reg == ST_STALL;
  assign buffer_done   = done_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_load_src_ptr: assert property (bc_wr[0] |=> // R1
    current_src_ptr[0] == $past(src_base_addr[0]) && buf_active_reg[0])
    else $error("source pointer not loaded from base");
  a_load_dst_ptr: assert property (bc_wr[1] |=> // R2
    current_dst_ptr[1] == $past(dst_base_addr[1]))
    else $error("destination pointer not loaded from base");
  a_end_src_saved: assert property (finish[0] |=> // R3
    current_src_ptr[0] == $past(current_src_ptr[0]) + {29'h0, $past(beat_bytes)}
    ##1 $stable(current_src_ptr[0]) || bc_wr[0])
    else $error("final source address not kept");
  a_end_dst_saved: assert property (finish[1] |=> // R4
    current_dst_ptr[1] == $past(current_dst_ptr[1]) + {29'h0, $past(beat_bytes)})
    else $error("final destination address not kept");
  a_idle_desc_safe: assert property (moving[0] && !beat_done |=> // R6
    $stable(current_src_ptr[0]) && $stable(current_dst_ptr[0]))
    else $error("running descriptor disturbed");
  a_read_cur_src: assert property (ar_fire && rd_addr == `OFS_CUR_SRC1 |=> // R9
    rvalid_reg && rdata_reg == $past(current_src_ptr[1]))
    else $error("current source pointer read mismatch");
  a_read_dst_base: assert property (ar_fire && rd_addr == `OFS_DST_BASE0 |=> // R10
    rdata_reg == $past(dst_base_addr[0]) && rresp_reg == `RESP_OKAY)
    else $error("destination base read mismatch");
  a_read_cur_dst: assert property (ar_fire && rd_addr == `OFS_CUR_DST1 |=> // R11
    rdata_reg == $past(current_dst_ptr[1]))
    else $error("current destination pointer read mismatch");
  a_zero_stalls: assert property (state_reg == ST_IDLE && trigger && // R15
    bytes_remaining[pick_idx] == 16'h0 |=> stalled [*2] or !enable_reg)
    else $error("zero count did not stall");
  a_beat_advance: assert property (beat_hit[1] && !last_beat |=> // R16
    current_src_ptr[1] == $past(current_src_ptr[1]) + {29'h0, $past(beat_bytes)})
    else $error("pointer did not advance by beat size");

  c_buffer_switch: cover property (finish[0] && other_ready && enable_reg ##1 moving[1]);
  c_stall_seen: cover property (state_reg == ST_IDLE && trigger ##1 stalled);
  c_second_armed: cover property (moving[0] && bc_wr[1]);
  c_slverr: cover property (bvalid_reg && bresp_reg == `RESP_SLVERR);
endmodule : m2m_dma_address_pointers
`default_nettype wire

// ### sim/m2m_dma_address_pointers_tb.sv
// Self-checking testbench for the DMA address pointer block
`timescale 1ns/1ps
`include "m2m_dma_ptr_cfg.svh"
`default_nettype none
module m2m_dma_address_pointers_tb;
  import m2m_dma_ptr_pkg::*;

  logic          aclk;
  logic          aresetn;
  axil_req_type  axi_req;
  axil_rsp_type  axi_rsp;
  logic          hw_trigger;
  logic          beat_done;
  logic          beat_req;
  logic [31:0]   beat_src_addr;
  logic [31:0]   beat_dst_addr;
  logic [2:0]    beat_bytes;
  logic          active_buf;
  logic          stalled;
  logic          buffer_done;
  int            err_total;
  int            checks_done;
  int            done_pulses;
  logic [31:0]   rd;
  logic [1:0]    resp;

  m2m_dma_address_pointers m2m_dma_address_pointers_inst (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .axi_req       (axi_req),
    .axi_rsp       (axi_rsp),
    .hw_trigger    (hw_trigger),
    .beat_done     (beat_done),
    .beat_req      (beat_req),
    .beat_src_addr (beat_src_addr),
    .beat_dst_addr (beat_dst_addr),
    .beat_bytes    (beat_bytes),
    .active_buf    (active_buf),
    .stalled       (stalled),
    .buffer_done   (buffer_done)
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Counting pulses avoids guessing the exact cycle of the done pulse
  always @(posedge aclk) begin
    if (buffer_done === 1'b1) begin
      done_pulses <= done_pulses + 1;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s seen=%h exp=%h", $time, msg, seen, exp);
    end
  endtask : chk

  // AXI4-Lite write: both channels offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    axi_req.awaddr  <= a;
    axi_req.awvalid <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hF;
    axi_req.wvalid  <= 1'b1;
    axi_req.bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (axi_req.awvalid && axi_rsp.awready === 1'b1) begin
        aw_ok = 1;
        axi_req.awvalid <= 1'b0;
      end
      if (axi_req.wvalid && axi_rsp.wready === 1'b1) begin
        w_ok = 1;
        axi_req.wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (axi_rsp.bvalid !== 1'b1);
    r = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    axi_req.araddr  <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready  <= 1'b1;
    do @(posedge aclk); while (axi_rsp.arready !== 1'b1);
    axi_req.arvalid <= 1'b0;
    while (axi_rsp.rvalid !== 1'b1) @(posedge aclk);
    d = axi_rsp.rdata;
    r = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask : axr

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axw(a, d, resp);
    chk({30'h0, resp}, {30'h0, `RESP_OKAY}, "write response");
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    axr(a, rd, resp);
    chk(rd, exp, msg);
    chk({30'h0, resp}, {30'h0, `RESP_OKAY}, "read response");
  endtask : rd_chk

  task automatic beat();
    @(posedge aclk);
    beat_done <= 1'b1;
    @(posedge aclk);
    beat_done <= 1'b0;
    #1;
  endtask : beat

  task automatic test_reset_map();
    rd_chk(`OFS_CUR_SRC0, `RST_WORD, "cur src0 reset");
    rd_chk(`OFS_CUR_SRC1, `RST_WORD, "cur src1 reset");
    rd_chk(`OFS_DST_BASE0, `RST_WORD, "dst base0 reset");
    rd_chk(`OFS_DST_BASE1, `RST_WORD, "dst base1 reset");
    rd_chk(`OFS_CUR_DST0, `RST_WORD, "cur dst0 reset");
    rd_chk(`OFS_CUR_DST1, `RST_WORD, "cur dst1 reset");
    wr(`OFS_CUR_SRC0, 32'hDEAD_BEEF);
    rd_chk(`OFS_CUR_SRC0, `RST_WORD, "cur src0 write ignored");
    wr(`OFS_CUR_DST1, 32'hABCD_0010);
    rd_chk(`OFS_CUR_DST1, 32'hABCD_0010, "cur dst1 writable");
    axr(8'h40, rd, resp);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR}, "unmapped read");
    axw(8'h44, 32'h0000_0001, resp);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR}, "unmapped write");
    $display("test reset_map done");
  endtask : test_reset_map

  task automatic test_arm_and_move();
    wr(`OFS_SRC_BASE0, 32'h0000_1000);
    wr(`OFS_DST_BASE0, 32'h0000_2000);
    wr(`OFS_SRC_BASE1, 32'h0000_3000);
    wr(`OFS_DST_BASE1, 32'h0000_4000);
    rd_chk(`OFS_DST_BASE0, 32'h0000_2000, "dst base0 rw");
    rd_chk(`OFS_DST_BASE1, 32'h0000_4000, "dst base1 rw");
    wr(`OFS_BYTE_COUNT0, 32'h0000_0008);
    rd_chk(`OFS_CUR_SRC0, 32'h0000_1000, "cur src0 loaded");
    rd_chk(`OFS_CUR_DST0, 32'h0000_2000, "cur dst0 loaded");
    axr(`OFS_STATUS, rd, resp);
    chk({31'h0, rd[0]}, 32'h1, "desc0 armed");
    // Word width, enable and start
    wr(`OFS_CONTROL, 32'h0000_000B);
    repeat (2) @(posedge aclk);
    #1;
    chk({31'h0, beat_req}, 32'h1, "move started");
    chk({29'h0, beat_bytes}, 32'h4, "word beat size");
    wr(`OFS_BYTE_COUNT1, 32'h0000_0004);
    #1;
    chk(beat_src_addr, 32'h0000_1000, "running src kept");
    chk(beat_dst_addr, 32'h0000_2000, "running dst kept");
    chk({31'h0, active_buf}, 32'h0, "still desc0");
    beat();
    chk(beat_src_addr, 32'h0000_1004, "src advance");
    chk(beat_dst_addr, 32'h0000_2004, "dst advance");
    beat();
    repeat (3) @(posedge aclk);
    #1;
    chk(done_pulses, 1, "buffer done pulse");
    chk({31'h0, active_buf}, 32'h1, "switched to desc1");
    chk(beat_src_addr, 32'h0000_3000, "desc1 src");
    rd_chk(`OFS_CUR_SRC0, 32'h0000_1008, "stop src0");
    rd_chk(`OFS_CUR_DST0, 32'h0000_2008, "stop dst0");
    beat();
    repeat (3) @(posedge aclk);
    #1;
    chk({31'h0, beat_req}, 32'h0, "idle after desc1");
    rd_chk(`OFS_CUR_SRC1, 32'h0000_3004, "stop src1");
    rd_chk(`OFS_CUR_DST1, 32'h0000_4004, "stop dst1");
    $display("test arm_and_move done");
  endtask : test_arm_and_move

  task automatic test_zero_count_stall();
    // Disable with half width selected
    wr(`OFS_CONTROL, 32'h0000_0004);
    chk({29'h0, beat_bytes}, 32'h2, "half beat size");
    wr(`OFS_BYTE_COUNT0, 32'h0000_0000);
    wr(`OFS_CONTROL, 32'h0000_0003);
    repeat (4) @(posedge aclk);
    #1;
    chk({31'h0, stalled}, 32'h1, "zero count stalls");
    chk({31'h0, beat_req}, 32'h0, "no beats on zero count");
    wr(`OFS_CONTROL, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    #1;
    chk({31'h0, stalled}, 32'h0, "stall left on disable");
    $display("test zero_count_stall done");
  endtask : test_zero_count_stall

  task automatic test_hw_trigger_bytes();
    wr(`OFS_DST_BASE0, 32'h0000_5000);
    wr(`OFS_BYTE_COUNT0, 32'h0000_0002);
    wr(`OFS_CONTROL, 32'h0000_0001);
    @(posedge aclk);
    hw_trigger <= 1'b1;
    @(posedge aclk);
    hw_trigger <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
    chk({31'h0, beat_req}, 32'h1, "hw trigger moves");
    chk(beat_dst_addr, 32'h0000_5000, "dst from base");
    chk({29'h0, beat_bytes}, 32'h1, "byte beat size");
    beat();
    beat();
    repeat (3) @(posedge aclk);
    rd_chk(`OFS_CUR_SRC0, 32'h0000_1002, "byte stop src0");
    rd_chk(`OFS_CUR_DST0, 32'h0000_5002, "byte stop dst0");
    $display("test hw_trigger_bytes done");
  endtask : test_hw_trigger_bytes

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    err_total   = 0;
    checks_done = 0;
    done_pulses = 0;
    axi_req     = '0;
    hw_trigger  = 1'b0;
    beat_done   = 1'b0;
    aresetn     = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_reset_map();
    test_arm_and_move();
    test_zero_count_stall();
    test_hw_trigger_bytes();
    tally_and_finish();
  end

  // Whole run needs well under a few thousand cycles
  initial begin
    #100000;
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule : m2m_dma_address_pointers_tb
`default_nettype wire
